/* File: logic/fdsr_params.svh */
// Register offsets, bit positions and fixed values of the drive status bank
`ifndef FDSR_PARAMS_SVH
`define FDSR_PARAMS_SVH

// ----------------------------------------------------------------------
// Register offsets on the port
// ----------------------------------------------------------------------
`define FDSR_OFS_STATUS_A 3'h0
`define FDSR_OFS_STATUS_B 3'h1
`define FDSR_OFS_DIGITAL_IN 3'h7
`define FDSR_OFS_CTRL 3'h6

// ----------------------------------------------------------------------
// Bit positions
// ----------------------------------------------------------------------
`define FDSR_A_IRQ 7
`define FDSR_A_DRV2 6
`define FDSR_A_DRQ 6
`define FDSR_A_STEP 5
`define FDSR_A_TRACK_ZERO_INV 4
`define FDSR_A_HEAD 3
`define FDSR_A_INDEX 2
`define FDSR_A_WPROT 1
`define FDSR_A_DIR 0
`define FDSR_B_DRV2 7
`define FDSR_B_DSB 6
`define FDSR_B_DSA 5
`define FDSR_B_WDATA 4
`define FDSR_B_RDATA 3
`define FDSR_B_WRITE_GATE_INV 2
`define FDSR_B_DSD 1
`define FDSR_B_DSC 0
`define FDSR_B_MOTB 1
`define FDSR_B_MOTA 0

// ----------------------------------------------------------------------
// Fixed values and reset values
// ----------------------------------------------------------------------
`define FDSR_B_RSVD_FIRST 2'h3
`define FDSR_CTRL_RESET 8'h00
`define FDSR_CTRL_MODE_BIT 0
`define FDSR_CTRL_RATE_LSB 1
`define FDSR_RATE_KBPS_250 2'h2
`define FDSR_RATE_KBPS_300 2'h1
`define FDSR_RATE_KBPS_500 2'h0
`define FDSR_RATE_MBPS_1 2'h3

`endif

/* File: logic/fdsr_pkg.sv */
// Types shared by the drive status bank
package fdsr_pkg;
	// Register layout selector
	typedef enum logic {
		FDSR_MODE_FIRST = 1'b0,
		FDSR_MODE_SECOND = 1'b1
	} fdsr_mode_t;

	// Transfer rate encoding
	typedef enum logic [1:0] {
		FDSR_RATE_500K = 2'h0,
		FDSR_RATE_300K = 2'h1,
		FDSR_RATE_250K = 2'h2,
		FDSR_RATE_1M = 2'h3
	} fdsr_rate_t;
endpackage

/* File: logic/fdsr_sync.sv */
// Three-stage pin synchroniser with agreement check and edge pulses
`timescale 1ns/1ps
module fdsr_sync #(
	parameter int WIDTH = 4
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Pins from outside the clock domain
	input wire logic [WIDTH-1:0] pin_in,
	// Filtered level and its edges
	output logic [WIDTH-1:0] level_out,
	output logic [WIDTH-1:0] rise_out,
	output logic [WIDTH-1:0] fall_out
);
	logic [WIDTH-1:0] s1_r;
	logic [WIDTH-1:0] s2_r;
	logic [WIDTH-1:0] s3_r;
	logic [WIDTH-1:0] lvl_r;
	logic [WIDTH-1:0] lvl_nxt;
	wire [WIDTH-1:0] agree;

	// A change counts only once stages two and three agree
	assign agree = ~(s2_r ^ s3_r);
	assign lvl_nxt = (agree & s3_r) | (~agree & lvl_r);

	// Chain and filtered level; the first stage feeds only the second
	always_ff @(posedge clk) begin
		if (rst) begin
			s1_r <= '0;
			s2_r <= '0;
			s3_r <= '0;
			lvl_r <= '0;
		end else begin
			s1_r <= pin_in;
			s2_r <= s1_r;
			s3_r <= s2_r;
			lvl_r <= lvl_nxt;
		end
	end

	// Edges are one-cycle pulses of the filtered level
	assign level_out = lvl_r;
	assign rise_out = lvl_nxt & ~lvl_r;
	assign fall_out = ~lvl_nxt & lvl_r;
endmodule

/* File: logic/fdsr_status_bank.sv */
// Floppy drive status registers A and B with two compatibility layouts
`timescale 1ns/1ps
`include "fdsr_params.svh"
module fdsr_status_bank (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Register port
	input wire logic [2:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// Controller state, same clock
	input wire logic irq_pending,
	input wire logic dma_request,
	input wire logic drive_select_mirror,
	input wire logic motor_a_on,
	input wire logic second_drive_absent,
	// Drive outputs, active low, driven by controller logic on this clock
	input wire logic step_out_n,
	input wire logic dir_out_n,
	input wire logic head_side_raw,
	input wire logic write_gate_out_n,
	input wire logic drive_a_select_raw,
	// Drive inputs and data lines from the pins, active low
	input wire logic track_zero_raw,
	input wire logic index_raw_n,
	input wire logic write_protect_raw,
	input wire logic read_data_n,
	input wire logic write_data_n,
	// Settings seen by the controller core
	output logic layout_mode,
	output logic [1:0] rate_sel
);
	// ------------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------------
	logic [4:0] pin_lvl;
	logic [4:0] pin_rise;
	logic [4:0] pin_fall;

	// Order: write data, read data, index, write protect, track zero
	// Data lines enter inverted so their idle high matches the cleared
	// chain; otherwise leaving reset would look like a rising edge
	fdsr_sync #(
		.WIDTH(5)
	) u_sync (
		.clk(clk),
		.rst(rst),
		.pin_in({~write_data_n, ~read_data_n, index_raw_n,
			write_protect_raw, track_zero_raw}),
		.level_out(pin_lvl),
		.rise_out(pin_rise),
		.fall_out(pin_fall)
	);

	wire track_zero_inv_s = pin_lvl[0];
	wire wprot_s = pin_lvl[1];
	wire index_s = pin_lvl[2];
	// A fall of the inverted copy is a rise of the line itself
	wire rdata_rise = pin_fall[3];
	wire wdata_rise = pin_fall[4];

	// Write gate comes from our own clock domain, so only an edge register
	logic write_gate_inv_d_r;
	wire write_gate_inv_fall = write_gate_inv_d_r & ~write_gate_out_n;

	// ------------------------------------------------------------------
	// Control register: layout mode and transfer rate
	// ------------------------------------------------------------------
	logic [7:0] ctrl_r;
	wire sel_a = (reg_addr == `FDSR_OFS_STATUS_A);
	wire sel_b = (reg_addr == `FDSR_OFS_STATUS_B);
	wire sel_din = (reg_addr == `FDSR_OFS_DIGITAL_IN);
	wire sel_ctrl = (reg_addr == `FDSR_OFS_CTRL);
	// Status offsets take no write at all
	wire ctrl_wr = reg_wr & sel_ctrl;
	wire din_rd = reg_rd & sel_din;

	assign layout_mode = ctrl_r[`FDSR_CTRL_MODE_BIT];
	// Any of the four encodings is a supported rate
	assign rate_sel = ctrl_r[`FDSR_CTRL_RATE_LSB +: 2];
	wire second = (layout_mode == fdsr_pkg::FDSR_MODE_SECOND);

	always_ff @(posedge clk) begin
		if (rst) begin
			ctrl_r <= `FDSR_CTRL_RESET;
		end else if (ctrl_wr) begin
			ctrl_r <= {5'h00, reg_wdata[2:0]};
		end
	end

	// ------------------------------------------------------------------
	// Step latch and data-line flags
	// ------------------------------------------------------------------
	logic latched_head_step;
	logic wdata_tog_r;
	logic rdata_tog_r;
	logic write_pulse_latch;
	logic read_pulse_latch;
	logic write_gate_latch;

	// Step latch catches a step pulse; cleared by the next status A read
	// so a short pulse is not missed between polls
	wire step_clr = reg_rd & sel_a;
	wire step_nxt = ~step_out_n | (latched_head_step & ~step_clr);

	// Toggles and latches: a set in the clearing cycle wins
	always_ff @(posedge clk) begin
		if (rst) begin
			write_gate_inv_d_r <= 1'b1;
			latched_head_step <= 1'b0;
			wdata_tog_r <= 1'b0;
			rdata_tog_r <= 1'b0;
			write_pulse_latch <= 1'b0;
			read_pulse_latch <= 1'b0;
			write_gate_latch <= 1'b0;
		end else begin
			write_gate_inv_d_r <= write_gate_out_n;
			latched_head_step <= step_nxt;
			wdata_tog_r <= wdata_tog_r ^ wdata_rise;
			rdata_tog_r <= rdata_tog_r ^ rdata_rise;
			write_pulse_latch <= wdata_rise
				| (write_pulse_latch & ~din_rd);
			read_pulse_latch <= rdata_rise
				| (read_pulse_latch & ~din_rd);
			write_gate_latch <= write_gate_inv_fall
				| (write_gate_latch & ~din_rd);
		end
	end

	// ------------------------------------------------------------------
	// Status A layouts
	// ------------------------------------------------------------------
	wire [7:0] stat_a_first;
	wire [7:0] stat_a_second;

	// Live bits follow their signals from reset onward
	assign stat_a_first[`FDSR_A_IRQ] = irq_pending;
	assign stat_a_first[`FDSR_A_DRV2] = second_drive_absent;
	assign stat_a_first[`FDSR_A_STEP] = ~step_out_n;
	assign stat_a_first[`FDSR_A_TRACK_ZERO_INV] = track_zero_inv_s;
	assign stat_a_first[`FDSR_A_HEAD] = ~head_side_raw;
	assign stat_a_first[`FDSR_A_INDEX] = index_s;
	assign stat_a_first[`FDSR_A_WPROT] = wprot_s;
	assign stat_a_first[`FDSR_A_DIR] = ~dir_out_n;

	assign stat_a_second[`FDSR_A_IRQ] = irq_pending;
	assign stat_a_second[`FDSR_A_DRQ] = dma_request;
	assign stat_a_second[`FDSR_A_STEP] = latched_head_step;
	assign stat_a_second[`FDSR_A_TRACK_ZERO_INV] = ~track_zero_inv_s;
	assign stat_a_second[`FDSR_A_HEAD] = head_side_raw;
	assign stat_a_second[`FDSR_A_INDEX] = ~index_s;
	assign stat_a_second[`FDSR_A_WPROT] = ~wprot_s;
	assign stat_a_second[`FDSR_A_DIR] = dir_out_n;

	// ------------------------------------------------------------------
	// Status B layouts
	// ------------------------------------------------------------------
	wire [7:0] stat_b_first;
	wire [7:0] stat_b_second;

	assign stat_b_first[7:6] = `FDSR_B_RSVD_FIRST;
	assign stat_b_first[`FDSR_B_DSA] = drive_select_mirror;
	assign stat_b_first[`FDSR_B_WDATA] = wdata_tog_r;
	assign stat_b_first[`FDSR_B_RDATA] = rdata_tog_r;
	assign stat_b_first[`FDSR_B_WRITE_GATE_INV] = ~write_gate_out_n;
	// Second motor output does not exist, so its bit is fixed
	assign stat_b_first[`FDSR_B_MOTB] = 1'b0;
	assign stat_b_first[`FDSR_B_MOTA] = motor_a_on;

	assign stat_b_second[`FDSR_B_DRV2] = second_drive_absent;
	assign stat_b_second[`FDSR_B_DSB] = 1'b1;
	assign stat_b_second[`FDSR_B_DSA] = drive_a_select_raw;
	assign stat_b_second[`FDSR_B_WDATA] = write_pulse_latch;
	assign stat_b_second[`FDSR_B_RDATA] = read_pulse_latch;
	assign stat_b_second[`FDSR_B_WRITE_GATE_INV] = write_gate_latch;
	assign stat_b_second[`FDSR_B_DSD] = 1'b1;
	assign stat_b_second[`FDSR_B_DSC] = 1'b1;

	// ------------------------------------------------------------------
	// Read path: data valid the cycle after the strobe
	// ------------------------------------------------------------------
	wire [7:0] stat_a = second ? stat_a_second : stat_a_first;
	wire [7:0] stat_b = second ? stat_b_second : stat_b_first;
	wire [7:0] rd_mux = sel_a ? stat_a :
		sel_b ? stat_b :
		sel_ctrl ? ctrl_r :
		8'h00;
	logic [7:0] rdata_r;

	// Unmapped offsets and the digital input slot read as zero
	always_ff @(posedge clk) begin
		if (rst) begin
			rdata_r <= 8'h00;
		end else if (reg_rd) begin
			rdata_r <= rd_mux;
		end else begin
			rdata_r <= 8'h00;
		end
	end

	assign reg_rdata = rdata_r;
endmodule

/* File: bench/fdsr_status_chk.sv */
// Port assertions for the drive status bank
`timescale 1ns/1ps
module fdsr_status_chk (
	// Clock, reset and register port
	input wire logic clk,
	input wire logic rst,
	input wire logic [2:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	// Controller state and drive outputs
	input wire logic irq_pending,
	input wire logic dma_request,
	input wire logic drive_select_mirror,
	input wire logic motor_a_on,
	input wire logic second_drive_absent,
	input wire logic step_out_n,
	input wire logic dir_out_n,
	input wire logic head_side_raw,
	input wire logic write_gate_out_n,
	input wire logic drive_a_select_raw,
	// Settings
	input wire logic layout_mode,
	input wire logic [1:0] rate_sel
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// Strobes decoded per offset
	wire rd_a = reg_rd && reg_addr == 3'h0;
	wire rd_b = reg_rd && reg_addr == 3'h1;
	wire wr_c = reg_wr && reg_addr == 3'h6;
	idle_zero_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
		else $error("read data not zero when idle");
	irq_level_a: assert property (rd_a |=> reg_rdata[7] == $past(irq_pending))
		else $error("status A interrupt bit wrong");
	mode_sel_a: assert property (wr_c |=> layout_mode == $past(reg_wdata[0]))
		else $error("layout select not taken");
	rate_sel_a: assert property (wr_c |=> rate_sel == $past(reg_wdata[2:1]))
		else $error("rate select not taken");
	first_a_a: assert property (rd_a && !layout_mode |=>
		reg_rdata[6:5] == {$past(second_drive_absent), !$past(step_out_n)} &&
		reg_rdata[3] == !$past(head_side_raw) &&
		reg_rdata[0] == !$past(dir_out_n)) else $error("first A wrong");
	second_a_a: assert property (rd_a && layout_mode |=>
		reg_rdata[6] == $past(dma_request) &&
		reg_rdata[3] == $past(head_side_raw) &&
		reg_rdata[0] == $past(dir_out_n)) else $error("second A wrong");
	first_b_a: assert property (rd_b && !layout_mode |=>
		reg_rdata[7:5] == {2'h3, $past(drive_select_mirror)} &&
		reg_rdata[2:0] == {!$past(write_gate_out_n), 1'b0, $past(motor_a_on)})
		else $error("first B wrong");
	second_b_a: assert property (rd_b && layout_mode |=>
		{reg_rdata[7:5], reg_rdata[1:0]} ==
		{$past(second_drive_absent), 1'b1, $past(drive_a_select_raw), 2'h3})
		else $error("second B wrong");
	unmapped_a: assert property (reg_rd && reg_addr inside {[3'h2:3'h5]} |=>
		reg_rdata == 8'h00) else $error("unmapped read not zero");
endmodule
bind fdsr_status_bank fdsr_status_chk u_fdsr_status_chk (.*);

/* File: bench/fdsr_drive_model.sv */
// Behavioural drive: sense levels and data line pulses
`timescale 1ns/1ps
module fdsr_drive_model (
	// Pacing clock
	input wire logic clk,
	// Drive lines, idle high as pulled up on the cable
	output logic track_zero_raw,
	output logic index_raw_n,
	output logic write_protect_raw,
	output logic read_data_n,
	output logic write_data_n
);
	// Idle levels at time zero
	initial begin
		{track_zero_raw, index_raw_n, write_protect_raw} = 3'h7;
		{read_data_n, write_data_n} = 2'h3;
	end
	// New sense levels just after an edge
	task automatic sense(input logic [2:0] s);
		@(posedge clk);
		{track_zero_raw, index_raw_n, write_protect_raw} <= s;
	endtask
	// Three-cycle low pulse; long enough to pass the synchroniser
	task automatic pulse(input logic wr);
		@(posedge clk);
		if (wr) write_data_n <= 1'b0;
		else read_data_n <= 1'b0;
		repeat (3) @(posedge clk);
		{read_data_n, write_data_n} <= 2'h3;
	endtask
endmodule

/* File: bench/fdsr_status_tb.sv */
// Self-checking bench for the drive status bank
`timescale 1ns/1ps
module testbench;
	logic clk, rst, reg_wr, reg_rd, layout_mode;
	logic [2:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, v;
	logic irq_pending, dma_request, drive_select_mirror, motor_a_on;
	logic second_drive_absent, step_out_n, dir_out_n, head_side_raw;
	logic write_gate_out_n, drive_a_select_raw, track_zero_raw;
	logic index_raw_n, write_protect_raw, read_data_n, write_data_n;
	logic [1:0] rate_sel;
	int miscompares, total_checks, cycles;
	logic [9:0] pc [2] = '{10'h2A9, 10'h156};
	logic [2:0] ps [2] = '{3'h5, 3'h2};
	fdsr_status_bank u_fdsr_status_bank (.*);
	fdsr_drive_model u_fdsr_drive_model (.*);
	// Clock and hang guard
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			miscompares++;
			test_done();
		end
	end
	task automatic test_done();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input string n, input logic [7:0] got, exp);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("Error %s expected %h seen %h", n, exp, got);
		end
	endtask
	// Register port cycles
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
		// Let the registered result settle before anyone looks at it
		#1;
	endtask
	task automatic rd(input logic [2:0] a);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask
	// Controller levels; pins need the synchroniser delay to show
	task automatic ctl(input logic [9:0] c);
		@(posedge clk);
		{irq_pending, dma_request, drive_select_mirror, motor_a_on,
			second_drive_absent, step_out_n, dir_out_n, head_side_raw,
			write_gate_out_n, drive_a_select_raw} <= c;
	endtask
	task automatic settle();
		repeat (6) @(posedge clk);
	endtask
	function automatic logic [7:0] exp_a(input logic m, stp);
		if (!m) return {irq_pending, second_drive_absent, ~step_out_n,
			track_zero_raw, ~head_side_raw, index_raw_n, write_protect_raw,
			~dir_out_n};
		return {irq_pending, dma_request, stp, ~track_zero_raw, head_side_raw,
			~index_raw_n, ~write_protect_raw, dir_out_n};
	endfunction
	function automatic logic [7:0] exp_b(input logic m, input logic [2:0] l);
		if (!m) return {2'h3, drive_select_mirror, l[2:1], ~write_gate_out_n,
			1'b0, motor_a_on};
		return {second_drive_absent, 1'b1, drive_a_select_raw, l, 2'h3};
	endfunction
	// First layout, two opposite patterns, then edge toggles
	task automatic t_first();
		for (int i = 0; i < 2; i++) begin
			ctl(pc[i]);
			u_fdsr_drive_model.sense(ps[i]);
			settle();
			rd(3'h0);
			chk("first A", v, exp_a(1'b0, 1'b0));
		end
		u_fdsr_drive_model.pulse(1'b1);
		u_fdsr_drive_model.pulse(1'b0);
		settle();
		rd(3'h1);
		chk("first B", v, exp_b(1'b0, 3'h6));
		u_fdsr_drive_model.pulse(1'b1);
		settle();
		rd(3'h1);
		chk("toggle B", v, exp_b(1'b0, 3'h2));
	endtask
	// Writes to read-only places, a read of an unmapped one, then all rate codes
	task automatic t_ro_rate();
		wr(3'h0, 8'hFF);
		wr(3'h1, 8'hFF);
		chk("layout", {7'h0, layout_mode}, 8'h00);
		rd(3'h5);
		chk("unmapped", v, 8'h00);
		for (int i = 0; i < 4; i++) begin
			wr(3'h6, 8'(i * 2));
			chk("rate", {6'h0, rate_sel}, 8'(i));
		end
	endtask
	// Second layout: levels, step latch, edge latches and their clear
	task automatic t_second();
		wr(3'h6, 8'h01);
		chk("layout", {7'h0, layout_mode}, 8'h01);
		for (int i = 0; i < 2; i++) begin
			ctl(pc[i] | 10'h010);
			u_fdsr_drive_model.sense(ps[i]);
			settle();
			rd(3'h0);
			chk("second A", v, exp_a(1'b1, 1'b0));
		end
		ctl(10'h002);
		ctl(10'h012);
		rd(3'h0);
		chk("step latch", v, exp_a(1'b1, 1'b1));
		rd(3'h0);
		chk("step clear", v, exp_a(1'b1, 1'b0));
		rd(3'h7);
		rd(3'h1);
		chk("second B", v, exp_b(1'b1, 3'h0));
		u_fdsr_drive_model.pulse(1'b1);
		settle();
		rd(3'h1);
		chk("write latch", v, exp_b(1'b1, 3'h4));
		u_fdsr_drive_model.pulse(1'b0);
		ctl(10'h330);
		settle();
		rd(3'h1);
		chk("all latches", v, exp_b(1'b1, 3'h7));
		rd(3'h7);
		rd(3'h1);
		chk("latch clear", v, exp_b(1'b1, 3'h0));
	endtask
	initial begin
		{reg_wr, reg_rd, reg_addr, reg_wdata, cycles} = '0;
		{miscompares, total_checks} = '0;
		{irq_pending, dma_request, drive_select_mirror, motor_a_on} = 4'h0;
		{second_drive_absent, step_out_n, dir_out_n, head_side_raw} = 4'h4;
		{write_gate_out_n, drive_a_select_raw} = 2'h2;
		rst = 1'b1;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		settle();
		rd(3'h0);
		chk("reset A", v, exp_a(1'b0, 1'b0));
		t_first();
		t_ro_rate();
		t_second();
		test_done();
	end
endmodule
